/* File: bench/adc_fifo_host_interface_tb.sv */
// adc_fifo_host_interface_tb: random and corner conversions, fifo reads, irq, axi
// assumes afh_top with one 125 MHz clock and the host model on the parallel pins
`default_nettype none
module adc_fifo_host_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import afh_pkg::*;
   logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic cs_n, rd_n, wr_n, a0, cv_n, over, under, db_oe, busy_n, alert_n, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, seed;
   logic [1:0] bresp, rresp, r;
   logic [11:0] db_in, db_out, code, w, c;
   logic [13:0] q[$];
   int mismatches, n_checks, cyc;

   afh_top uut (.CLK_SYS(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CS_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
      .ADDR0(a0), .CONVERT_START_N(cv_n), .DB_IN(db_in), .DB_OUT(db_out),
      .DB_OE(db_oe), .ADC_CODE(code), .ADC_OVER(over), .ADC_UNDER(under),
      .BUSY_N(busy_n), .FIFO_LEVEL_ALERT_N(alert_n), .IRQ(irq));

   afh_host_model m (.clk(clk), .busy_n(busy_n), .db_out(db_out), .db_oe(db_oe),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .cv_n(cv_n), .db_in(db_in),
      .code(code), .over(over), .under(under));

   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // expected status word, alert enabled, idle converter
   function automatic logic [31:0] st_exp(input int cnt, input logic rng);
      logic [31:0] v;
      v = 32'(cnt) << ST_CNT_LSB;
      v[ST_EMPTY] = (cnt == 0);
      v[ST_RANGE] = rng;
      v[ST_ALERT_EN] = 1'b1;
      return v;
   endfunction : st_exp

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
      @(posedge clk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      dv = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   // watchdog well beyond thirteen conversion periods of about 10.5 us each
   initial begin
      #300us;
      mismatches++;
      end_sim();
   end

   // main sequence
   initial begin
      {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      seed = 32'h749A17F3;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge clk);
      m.pwrite(12'h043);
      axi_rd(REG_STATUS, d, r);
      chk(d, st_exp(0, 1'b0));
      axi_wr(REG_IRQ_MASK, 32'h7, r);
      chk(r, RESP_OKAY);
      // fill to the programmed length: corner code, out of range, random
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         c = (i == 0) ? 12'h800 : seed[11:0];
         m.convert(c, i == 1, 1'b0, cyc);
         q.push_back({i == 1, 1'b0, c});
         chk(cyc >= 56 && cyc <= 57, 1'b1);
         chk(alert_n, i < 2);
      end
      chk(irq, 1'b1);
      axi_rd(REG_STATUS, d, r);
      chk(d, st_exp(3, 1'b1));
      axi_rd(REG_HEAD, d, r);
      chk(d, 32'(q[0]));
      m.pread(1'b1, w);
      chk(w[ST_RANGE], 1'b1);
      // drain oldest first, alert follows the count
      for (int i = 0; i < 3; i++) begin
         m.pread(1'b0, w);
         chk(w, q[i][11:0]);
         chk(alert_n, 1'b1);
      end
      chk(db_oe, 1'b0);
      axi_rd(REG_STATUS, d, r);
      chk(d, st_exp(0, 1'b0));
      axi_rd(REG_IRQ_STAT, d, r);
      chk(d, 32'h3);
      axi_wr(REG_IRQ_STAT, 32'h3, r);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      // masked underrange sample: sticky bit set, no interrupt
      axi_wr(REG_IRQ_MASK, 32'h0, r);
      m.convert(12'h7FF, 1'b0, 1'b1, cyc);
      chk(irq, 1'b0);
      axi_rd(REG_HEAD, d, r);
      chk(d, 32'h17FF);
      axi_rd(REG_IRQ_STAT, d, r);
      chk(d, 32'h2);
      axi_rd(8'h40, d, r);
      chk(r, RESP_SLVERR);
      axi_wr(8'h44, 32'h1, r);
      chk(r, RESP_SLVERR);
      // discard after a range error and rewrite control
      m.pread(1'b0, w);
      chk(w, 12'h7FF);
      m.pwrite(12'h045);
      axi_rd(REG_CTRL, d, r);
      chk(d, 32'h45);
      // length code 0 means full depth; the ninth sample overflows
      axi_wr(REG_CTRL, 32'h40, r);
      chk(r, RESP_OKAY);
      axi_wr(REG_IRQ_STAT, 32'h7, r);
      q.delete();
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         m.convert(seed[11:0], 1'b0, 1'b0, cyc);
         q.push_back({2'b00, seed[11:0]});
         chk(alert_n, i < 7);
      end
      axi_rd(REG_STATUS, d, r);
      chk(d, st_exp(8, 1'b0) | 32'h80);
      axi_rd(REG_IRQ_STAT, d, r);
      chk(d, 32'h5);
      for (int i = 0; i < 8; i++) begin
         m.pread(1'b0, w);
         chk(w, q[i][11:0]);
      end
      chk(irq, 1'b0);
      end_sim();
   end
endmodule : adc_fifo_host_interface_tb
`default_nettype wire

/* File: bench/afh_host_model.sv */
// afh_host_model: host processor, glue and conversion timer on the parallel pins
// assumes the device runs from the same clk; pins change just after a rising edge
`default_nettype none
module afh_host_model (
   input wire logic clk,
   input wire logic busy_n,
   input wire logic [afh_pkg::DATA_W-1:0] db_out,
   input wire logic db_oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic a0,
   output logic cv_n,
   output logic [afh_pkg::DATA_W-1:0] db_in,
   output logic [afh_pkg::DATA_W-1:0] code,
   output logic over,
   output logic under
);
   timeunit 1ns;
   timeprecision 1ps;
   import afh_pkg::*;

   // idle pins: strobes high, separate read and write strobes
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      a0 = 1'b0;
      cv_n = 1'b1;
      db_in = 12'hA5A;
      code = 12'h000;
      over = 1'b0;
      under = 1'b0;
   end

   // glue stall: no access while the device converts
   task automatic wait_idle();
      while (!busy_n) @(posedge clk);
   endtask : wait_idle

   // timer-driven start, independent of the bus program
   task automatic convert(input logic [11:0] c, input logic ov, input logic un,
                          output int cyc);
      @(posedge clk);
      code <= c;
      over <= ov;
      under <= un;
      cv_n <= 1'b0;
      repeat (2) @(posedge clk);
      cv_n <= 1'b1;
      cyc = 0;
      while (busy_n) @(posedge clk);
      code <= ~c; // held sample no longer shown
      while (!busy_n) begin
         @(posedge clk);
         cyc++;
      end
      repeat (1250) @(posedge clk);
   endtask : convert

   // one read cycle, word taken while the device drives the lines
   task automatic pread(input logic a, output logic [11:0] w);
      wait_idle();
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      a0 <= a;
      do @(posedge clk); while (!db_oe);
      w = db_out;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      do @(posedge clk); while (db_oe);
   endtask : pread

   // control write, data held through the strobe rise
   task automatic pwrite(input logic [11:0] d);
      wait_idle();
      @(posedge clk);
      db_in <= d;
      cs_n <= 1'b0;
      a0 <= 1'b1;
      wr_n <= 1'b0;
      repeat (2) @(posedge clk);
      wr_n <= 1'b1;
      @(posedge clk);
      cs_n <= 1'b1;
      db_in <= ~d; // released lines change
      repeat (6) @(posedge clk);
   endtask : pwrite
endmodule : afh_host_model
`default_nettype wire

/* File: hdl/afh_pkg.sv */
// afh_pkg: constants and carrier types for the converter result fifo host port
// assumes one system clock shared by the host bus and the converter
`default_nettype none
package afh_pkg;
   // converter and fifo shape
   localparam int DATA_W = 12;
   localparam int FIFO_DEPTH = 8;
   localparam int WORD_W = DATA_W + 2;
   localparam int PTR_W = 3;
   localparam int CNT_W = 4;

   // timing: clock rate and conversion length in clock cycles
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CONV_TIME_PS = 448000;
   localparam logic [5:0] CONV_CYC = 6'(CONV_TIME_PS / CLK_PERIOD_PS);

   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_HEAD = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;

   // control field positions (same layout on the parallel bus)
   localparam int CTRL_LEN_LSB = 0;
   localparam int CTRL_ALERT_EN = 6;
   localparam logic [3:0] CTRL_LEN_RST = 4'h0;

   // status field positions
   localparam int ST_CNT_LSB = 0;
   localparam int ST_EMPTY = 4;
   localparam int ST_RANGE = 5;
   localparam int ST_ALERT_EN = 6;
   localparam int ST_UNDER = 7;
   localparam int ST_OVER = 8;
   localparam int ST_BUSY = 9;

   // fifo word layout
   localparam int WD_UNDER = 12;
   localparam int WD_OVER = 13;

   // interrupt event bits
   localparam int IRQ_W = 3;
   localparam int IRQ_LEVEL = 0;
   localparam int IRQ_RANGE = 1;
   localparam int IRQ_OVFL = 2;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // pin bundle passed through the synchroniser
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic a0;
      logic cv_n;
      logic over;
      logic under;
      logic [DATA_W-1:0] code;
      logic [DATA_W-1:0] db;
   } afh_pins_t;
endpackage : afh_pkg
`default_nettype wire

/* File: hdl/afh_top.sv */
// afh_top: result fifo, conversion sequencer, parallel host port and axi4-lite slave
// assumes host bus pins share CLK_SYS and a two-way data bus is resolved outside
`default_nettype none

module afh_top (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic CS_N,
   input wire logic READ_STROBE_N,
   input wire logic WRITE_STROBE_N,
   input wire logic ADDR0,
   input wire logic CONVERT_START_N,
   input wire logic [afh_pkg::DATA_W-1:0] DB_IN,
   output logic [afh_pkg::DATA_W-1:0] DB_OUT,
   output logic DB_OE,
   input wire logic [afh_pkg::DATA_W-1:0] ADC_CODE,
   input wire logic ADC_OVER,
   input wire logic ADC_UNDER,
   output logic BUSY_N,
   output logic FIFO_LEVEL_ALERT_N,
   output logic IRQ
);
   import afh_pkg::*;

   typedef struct packed {
      afh_pins_t s1;
      afh_pins_t s2;
      afh_pins_t p;
      logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
      logic [PTR_W-1:0] wp;
      logic [PTR_W-1:0] rp;
      logic [CNT_W-1:0] cnt;
      logic [3:0] len;
      logic alert_en;
      logic busy_n;
      logic [5:0] ccnt;
      logic [WORD_W-1:0] held;
      logic last_under;
      logic last_over;
      logic alert_n;
      logic [DATA_W-1:0] db_out;
      logic db_oe;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic awready;
      logic aw_full;
      logic [7:0] aw_addr;
      logic wready;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_host_access_strobe;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } afh_state_t;

   // strobes idle high so no edge is seen at reset release
   localparam afh_state_t ST_RST = '{s1: '1, s2: '1, p: '1, alert_n: 1'b1, busy_n: 1'b1,
                                     len: CTRL_LEN_RST, default: '0};

   logic [1:0] rst_q;
   logic rst_n;
   afh_state_t st;
   afh_state_t nx;
   afh_pins_t pins;
   logic push;
   logic pop;
   logic rd_act;
   logic cv_rise;
   logic wr_rise;
   logic range_any;
   logic [11:0] status;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;

   // effective fifo length: code 0 means the full depth
   function automatic logic [CNT_W-1:0] eff_len(input logic [3:0] l);
      eff_len = (l == 4'h0 || l > 4'(FIFO_DEPTH)) ? CNT_W'(FIFO_DEPTH) : l;
   endfunction : eff_len

   // reset release through two flip-flops
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // pin bundle into the synchroniser
   assign pins = '{cs_n: CS_N, rd_n: READ_STROBE_N, wr_n: WRITE_STROBE_N, a0: ADDR0,
                   cv_n: CONVERT_START_N, over: ADC_OVER, under: ADC_UNDER,
                   code: ADC_CODE, db: DB_IN};

   // strobe decode on synchronised pins
   assign rd_act = !st.s2.cs_n && !st.s2.rd_n;
   assign pop = !st.s2.cs_n && !st.s2.rd_n && st.p.rd_n && !st.s2.a0 && st.cnt != 4'h0;
   assign wr_rise = !st.p.cs_n && !st.p.wr_n && st.s2.wr_n && st.p.a0;
   assign cv_rise = st.s2.cv_n && !st.p.cv_n;
   assign push = !st.busy_n && st.ccnt == 6'h0 && !rd_act;

   // out-of-range summary over occupied words
   always_comb begin
      range_any = 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         // distance wraps at the pointer width before it is compared with the count
         if (CNT_W'(PTR_W'(PTR_W'(i) - st.rp)) < st.cnt) begin
            range_any = range_any | st.mem[i][WD_UNDER] | st.mem[i][WD_OVER];
         end
      end
   end

   // status word shared by both buses
   always_comb begin
      status = 12'h000;
      status[ST_CNT_LSB +: CNT_W] = st.cnt;
      status[ST_EMPTY] = st.cnt == 4'h0;
      status[ST_RANGE] = range_any;
      status[ST_ALERT_EN] = st.alert_en;
      status[ST_UNDER] = st.last_under;
      status[ST_OVER] = st.last_over;
      status[ST_BUSY] = !st.busy_n;
   end

   // axi read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = RESP_OKAY;
      case (S_AXI_ARADDR)
         REG_CTRL: rd_word = {25'h0, st.alert_en, 2'h0, st.len};
         REG_STATUS: rd_word = {20'h0, status};
         REG_HEAD: rd_word = {18'h0, st.mem[st.rp]};
         REG_IRQ_STAT: rd_word = {29'h0, st.irq_st};
         REG_IRQ_MASK: rd_word = {29'h0, st.irq_mask};
         default: rd_resp = RESP_SLVERR;
      endcase
   end

   // next state of the whole block
   always_comb begin
      nx = st;
      ev = '0;
      clr = '0;
      nx.s1 = pins;
      nx.s2 = st.s1;
      nx.p = st.s2;
      // conversion sequencer
      if (cv_rise && st.busy_n) begin
         nx.held = {st.s2.over, st.s2.under, st.s2.code};
         nx.busy_n = 1'b0;
         nx.ccnt = CONV_CYC - 6'h1;
      end else if (!st.busy_n && !rd_act) begin
         if (st.ccnt == 6'h0) begin
            nx.busy_n = 1'b1;
         end else begin
            nx.ccnt = st.ccnt - 6'h1;
         end
      end
      // fifo push, new sample dropped when full
      if (push) begin
         if (st.cnt == 4'(FIFO_DEPTH) && !pop) begin
            ev[IRQ_OVFL] = 1'b1;
         end else begin
            nx.mem[st.wp] = st.held;
            nx.wp = st.wp + 3'h1;
            ev[IRQ_RANGE] = st.held[WD_UNDER] | st.held[WD_OVER]; // only stored samples
         end
      end
      // parallel read: data drive only during select and read
      nx.db_oe = rd_act;
      if (!st.s2.cs_n && !st.s2.rd_n && st.p.rd_n) begin
         nx.db_out = st.s2.a0 ? status : st.mem[st.rp][DATA_W-1:0];
      end
      if (pop) begin
         nx.rp = st.rp + 3'h1;
         nx.last_under = st.mem[st.rp][WD_UNDER];
         nx.last_over = st.mem[st.rp][WD_OVER];
      end
      nx.cnt = st.cnt + CNT_W'(push && !ev[IRQ_OVFL]) - CNT_W'(pop);
      // parallel control write sampled with the strobe still low
      if (wr_rise) begin
         nx.len = st.p.db[CTRL_LEN_LSB +: 4];
         nx.alert_en = st.p.db[CTRL_ALERT_EN];
      end
      // axi write channel capture
      if (st.awready && S_AXI_AWVALID) begin
         nx.aw_full = 1'b1;
         nx.aw_addr = S_AXI_AWADDR;
      end
      if (st.wready && S_AXI_WVALID) begin
         nx.w_full = 1'b1;
         nx.w_data = S_AXI_WDATA;
         nx.w_host_access_strobe = S_AXI_WSTRB;
      end
      if (st.bvalid && S_AXI_BREADY) begin
         nx.bvalid = 1'b0;
      end
      if (st.aw_full && st.w_full && !st.bvalid) begin
         nx.aw_full = 1'b0;
         nx.w_full = 1'b0;
         nx.bvalid = 1'b1;
         nx.bresp = RESP_OKAY;
         case (st.aw_addr)
            REG_CTRL: begin
               if (st.w_host_access_strobe[0]) begin
                  nx.len = st.w_data[CTRL_LEN_LSB +: 4];
                  nx.alert_en = st.w_data[CTRL_ALERT_EN];
               end
            end
            REG_STATUS, REG_HEAD: ;
            REG_IRQ_STAT: clr = st.w_host_access_strobe[0] ? st.w_data[IRQ_W-1:0] : '0;
            REG_IRQ_MASK: begin
               if (st.w_host_access_strobe[0]) begin
                  nx.irq_mask = st.w_data[IRQ_W-1:0];
               end
            end
            default: nx.bresp = RESP_SLVERR;
         endcase
      end
      nx.awready = !nx.aw_full && !nx.bvalid;
      nx.wready = !nx.w_full && !nx.bvalid;
      // axi read channel
      if (st.rvalid && S_AXI_RREADY) begin
         nx.rvalid = 1'b0;
      end
      if (st.arready && S_AXI_ARVALID) begin
         nx.rvalid = 1'b1;
         nx.rdata = rd_word;
         nx.rresp = rd_resp;
      end
      nx.arready = !nx.rvalid;
      // level alert from the updated count
      nx.alert_n = !(nx.alert_en && nx.cnt >= eff_len(nx.len));
      ev[IRQ_LEVEL] = !nx.alert_n && st.alert_n;
      // sticky events, set wins over clear
      nx.irq_st = (st.irq_st & ~clr) | ev;
      nx.irq = |(nx.irq_st & nx.irq_mask);
   end

   // state register
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RST;
      end else begin
         st <= nx;
      end
   end

   // outputs straight from the state register
   assign S_AXI_AWREADY = st.awready;
   assign S_AXI_WREADY = st.wready;
   assign S_AXI_BRESP = st.bresp;
   assign S_AXI_BVALID = st.bvalid;
   assign S_AXI_ARREADY = st.arready;
   assign S_AXI_RDATA = st.rdata;
   assign S_AXI_RRESP = st.rresp;
   assign S_AXI_RVALID = st.rvalid;
   assign DB_OUT = st.db_out;
   assign DB_OE = st.db_oe;
   assign BUSY_N = st.busy_n;
   assign FIFO_LEVEL_ALERT_N = st.alert_n;
   assign IRQ = st.irq;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!rst_n);

   // checks next to the logic they guard
   alert_level_a: assert property (
      (st.alert_en && st.cnt >= eff_len(st.len)) |-> !FIFO_LEVEL_ALERT_N)
      else $error("alert not active at programmed level");
   read_data_a: assert property (
      pop |=> DB_OUT == $past(st.mem[st.rp][DATA_W-1:0]))
      else $error("read data is not the oldest sample");
   ctrl_write_a: assert property (
      (wr_rise && !(st.aw_full && st.w_full && !st.bvalid)) |=> st.len == $past(st.p.db[3:0]))
      else $error("control write did not set length");
   range_flag_a: assert property (
      (push && (st.held[WD_OVER] | st.held[WD_UNDER]) && st.cnt != 4'(FIFO_DEPTH))
      |=> status[ST_RANGE])
      else $error("range flag not set after bad sample");
   word_flag_a: assert property (
      pop |=> st.last_over == $past(st.mem[st.rp][WD_OVER]))
      else $error("per word range flag wrong");
   conv_length_a: assert property (
      $rose(!BUSY_N) |-> ##55 !BUSY_N)
      else $error("conversion ended early");
   conv_done_a: assert property (
      ($rose(!BUSY_N) ##1 !rd_act [*8]) |-> ##[47:300] $rose(BUSY_N))
      else $error("conversion did not finish");
   hold_sample_a: assert property (
      (cv_rise && BUSY_N) |=> !BUSY_N
      && st.held == {$past(st.s2.over), $past(st.s2.under), $past(st.s2.code)})
      else $error("sample not held on start edge");
   pop_count_a: assert property (
      (pop && !push) |=> st.cnt == $past(st.cnt) - 4'h1)
      else $error("count did not drop on read");
   drive_gate_a: assert property (
      DB_OE |-> $past(rd_act))
      else $error("data driven outside select and read");
endmodule : afh_top
`default_nettype wire
